// [logic/servo_stop_pkg.sv]
// constants, types and object layout for the servo stop sequencer
// assumes one 25 MHz clock and host-driven object access
// How it works
// - three stop methods: reverse, coast, dynamic
// - reverse method drives torque against rotation
// - coast cuts power, no active deceleration
// - post-stop states: free, dynamic brake, brake-hold
// - disable stop uses disable selection
// - reverse torque magnitude from brake torque setting
// - decel ends on timeout or zero speed
// - decel end: brake applied, dynamic brake on only for dynamic brake post-stop state
// - alarm stop uses alarm selection
// - brake output high means brake released
// - ack first, commands permitted after holdoff
// - nonzero pulse setting wins, else feed constant
// - pulse setting 0..8388608, applied on restart
// - encoder fixed at 23 bits, 8388608 counts
// - feed differs: encoder increments over feed
// - feed equals: motor revolutions over feed
// - gear objects 1..2147483647, default one
// - encoder resolution read-only 32-bit object
package servo_stop_pkg;
	// clock and timing
	localparam int unsigned CLK_NS        = 40;
	localparam int unsigned MS_NS         = 1000000;
	localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_NS;
	localparam logic [15:0] CMD_HOLDOFF_MS = 16'h0064;
	// encoder and range limits
	localparam logic [31:0] ENC_COUNTS  = 32'h0080_0000;
	localparam logic [31:0] PPR_MAX     = 32'h0080_0000;
	localparam logic [31:0] GEAR_MAX    = 32'h7FFF_FFFF;
	localparam logic [31:0] MIN_DIV     = 32'h0000_1F40;
	localparam logic [31:0] PPR_MIN_CMD = (ENC_COUNTS + MIN_DIV - 32'h1) / MIN_DIV;
	// object indices and subindices
	localparam logic [15:0] IDX_PPR     = 16'h2008;
	localparam logic [15:0] IDX_ENC_RES = 16'h608F;
	localparam logic [15:0] IDX_GEAR    = 16'h6091;
	localparam logic [15:0] IDX_FEED    = 16'h6092;
	localparam logic [7:0]  SUB_PPR     = 8'h00;
	localparam logic [7:0]  SUB_ENC_RES = 8'h01;
	localparam logic [7:0]  SUB_MOTOR   = 8'h01;
	localparam logic [7:0]  SUB_SHAFT   = 8'h02;
	localparam logic [7:0]  SUB_FEED    = 8'h01;
	// reset values
	localparam logic [31:0] PPR_RST     = 32'h0000_0000;
	localparam logic [31:0] ENC_RES_RST = 32'h0000_0000;
	localparam logic [31:0] GEAR_RST    = 32'h0000_0001;
	localparam logic [31:0] FEED_RST    = 32'h0000_2710;

	typedef enum logic [1:0] {
		METH_REVERSE = 2'h0,
		METH_COAST   = 2'h1,
		METH_DYN     = 2'h2
	} stop_method_t;

	typedef enum logic [1:0] {
		POST_FREE = 2'h0,
		POST_DYN  = 2'h1,
		POST_HOLD = 2'h2
	} post_state_t;

	typedef enum logic [2:0] {
		ST_STOPPED = 3'b001,
		ST_RUN     = 3'b010,
		ST_DECEL   = 3'b100
	} stop_state_t;

	typedef struct packed {
		logic [1:0] post;
		logic [1:0] method;
	} stop_select_t;

	typedef struct packed {
		logic        write;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] data;
	} obj_req_t;

	typedef struct packed {
		logic [31:0] num;
		logic [31:0] den;
	} gear_t;
endpackage : servo_stop_pkg

// [logic/gear_ratio_select.sv]
// electronic gear ratio source selection with divisor guard
// assumes inputs are stable configuration registers
`timescale 1ns/10ps
`default_nettype none
module gear_ratio_select
	import servo_stop_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic [31:0] pprApplied,
	input  wire logic [31:0] encRes,
	input  wire logic [31:0] motorRev,
	input  wire logic [31:0] feed,
	output gear_t            gearRatio,
	output logic             gearFromSetting,
	output logic             gearClamped,
	output logic             pprTooLow
);
	gear_t next_gear;
	logic  next_clamped;

	////////////////////////////////////////////////////////////////
	// pick numerator and denominator source
	always_comb begin
		next_clamped = 1'b0;
		if (pprApplied != 32'h0) begin
			next_gear.num = ENC_COUNTS;
			next_gear.den = pprApplied;
		end else if (feed != encRes) begin
			next_gear.num = encRes;
			next_gear.den = feed;
		end else begin
			next_gear.num = motorRev;
			next_gear.den = feed;
		end
		// a zero divisor would poison the scaling divider downstream
		if (next_gear.den == 32'h0) begin
			next_gear.den = 32'h1;
			next_clamped = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// registered ratio outputs
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			gearRatio       <= '{num: GEAR_RST, den: GEAR_RST};
			gearFromSetting <= 1'b0;
			gearClamped     <= 1'b0;
			pprTooLow       <= 1'b0;
		end else begin
			gearRatio       <= next_gear;
			gearFromSetting <= pprApplied != 32'h0;
			gearClamped     <= next_clamped;
			// flag only; the host owns keeping this legal
			pprTooLow       <= (pprApplied != 32'h0) && (pprApplied < PPR_MIN_CMD);
		end
	end
endmodule : gear_ratio_select
`default_nettype wire

// [logic/servo_stop_and_gear_ratio.sv]
// servo stop sequencer, brake and enable acknowledge, gear objects
// assumes synchronous inputs; host drives object requests one per cycle
`timescale 1ns/10ps
`default_nettype none
module servo_stop_and_gear_ratio
	import servo_stop_pkg::*;
#(
	parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	input  wire logic               servoEnable,
	input  wire logic               alarm,
	input  wire logic               restartReq,
	input  wire logic signed [31:0] motorSpeed,
	input  wire stop_select_t       disableStopSelect,
	input  wire stop_select_t       alarmStopSelect,
	input  wire logic [15:0]        stopBrakeTorque,
	input  wire logic [15:0]        stopDecelTimeout,
	input  wire logic [31:0]        stopZeroSpeedLevel,
	input  wire logic               objValid,
	input  wire obj_req_t           objReq,
	output logic                    objAck,
	output logic                    objError,
	output logic [31:0]             objRdData,
	output logic                    powerOn,
	output logic                    dynBrakeOn,
	output logic                    brakeReleaseAsserted,
	output logic                    servoOnAck,
	output logic                    cmdPermitted,
	output logic                    stopActive,
	output logic signed [31:0]      torqueCmd,
	output gear_t                   gearRatio,
	output logic                    gearFromSetting,
	output logic                    gearClamped,
	output logic                    pprTooLow
);
	stop_state_t  state;
	stop_state_t  next_state;
	stop_select_t activeSel;
	logic         alarmStop;
	logic         enPrev;
	logic         enRise;
	logic         stateChange;
	logic [31:0]  msDiv;
	logic         msTick;
	logic [15:0]  msCount;
	logic [31:0]  speedMag;
	logic         belowZero;
	logic         decelDone;
	logic signed [31:0] brakeTorque;

	logic [31:0]  pprSetting;
	logic [31:0]  pprApplied;
	logic [31:0]  encRes;
	logic [31:0]  motorRev;
	logic [31:0]  shaftRev;
	logic [31:0]  feed;
	logic [4:0]   sel;
	logic         hit;
	logic         readOnly;
	logic         inRange;
	logic         gearOk;
	logic         wrOk;
	logic [31:0]  rdVal;

	////////////////////////////////////////////////////////////////
	// millisecond enable, restarted on every state change
	assign stateChange = state != next_state;
	assign msTick      = msDiv == MS_CYCLES - 1;

	always_ff @(posedge clk_sys) begin
		if (!nrst || stateChange || msTick) begin
			msDiv <= 32'h0;
		end else begin
			msDiv <= msDiv + 32'h1;
		end
	end

	// elapsed milliseconds in the present state, saturating
	always_ff @(posedge clk_sys) begin
		if (!nrst || stateChange) begin
			msCount <= 16'h0;
		end else if (msTick && msCount != 16'hFFFF) begin
			msCount <= msCount + 16'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// enable edge; a held enable never restarts after an alarm stop
	assign enRise = servoEnable && !enPrev;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			enPrev <= 1'b0;
		end else begin
			enPrev <= servoEnable;
		end
	end

	////////////////////////////////////////////////////////////////
	// end of deceleration: zero speed or timeout, first wins
	assign speedMag  = motorSpeed[31] ? 32'(-motorSpeed) : 32'(motorSpeed);
	assign belowZero = speedMag < stopZeroSpeedLevel;
	assign decelDone = belowZero || (msCount >= stopDecelTimeout);

	// reverse torque opposes the present rotation
	assign brakeTorque = motorSpeed[31] ? $signed({16'h0, stopBrakeTorque})
	                                    : -$signed({16'h0, stopBrakeTorque});

	////////////////////////////////////////////////////////////////
	// sequencer next state
	always_comb begin
		next_state = state;
		unique case (state)
			ST_STOPPED: begin
				if (enRise && !alarm) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (alarm || !servoEnable) begin
					next_state = ST_DECEL;
				end
			end
			ST_DECEL: begin
				if (decelDone) begin
					next_state = ST_STOPPED;
				end
			end
			default: begin
				next_state = ST_STOPPED;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state <= ST_STOPPED;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////
	// stop selection latch; alarm overrides a running disable stop
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			activeSel <= '{post: POST_FREE, method: METH_COAST};
			alarmStop <= 1'b0;
		end else if (state == ST_RUN && alarm) begin
			activeSel <= alarmStopSelect;
			alarmStop <= 1'b1;
		end else if (state == ST_RUN && !servoEnable) begin
			activeSel <= disableStopSelect;
			alarmStop <= 1'b0;
		end else if (state == ST_DECEL && alarm && !alarmStop) begin
			activeSel <= alarmStopSelect;
			alarmStop <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// power stage, brake and acknowledge; outputs lag state by one cycle
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			powerOn              <= 1'b0;
			dynBrakeOn           <= 1'b0;
			brakeReleaseAsserted <= 1'b0;
			servoOnAck           <= 1'b0;
			stopActive           <= 1'b0;
			torqueCmd            <= 32'sh0;
		end else begin
			unique case (state)
				ST_RUN: begin
					powerOn              <= 1'b1;
					dynBrakeOn           <= 1'b0;
					brakeReleaseAsserted <= 1'b1;
					servoOnAck           <= 1'b1;
					stopActive           <= 1'b0;
					torqueCmd            <= 32'sh0;
				end
				ST_DECEL: begin
					// brake stays released while the rotor may still move
					brakeReleaseAsserted <= 1'b1;
					servoOnAck           <= 1'b0;
					stopActive           <= 1'b1;
					// an unused method code falls back to coasting
					powerOn    <= activeSel.method == METH_REVERSE;
					dynBrakeOn <= activeSel.method == METH_DYN;
					torqueCmd  <= (activeSel.method == METH_REVERSE) ? brakeTorque : 32'sh0;
				end
				default: begin
					// stopped: power off, brake applied, post-stop state held
					powerOn              <= 1'b0;
					brakeReleaseAsserted <= 1'b0;
					dynBrakeOn           <= activeSel.post == POST_DYN;
					servoOnAck           <= 1'b0;
					stopActive           <= 1'b0;
					torqueCmd            <= 32'sh0;
				end
			endcase
		end
	end

	// commands permitted only after a holdoff behind the acknowledge
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cmdPermitted <= 1'b0;
		end else begin
			cmdPermitted <= state == ST_RUN && msCount >= CMD_HOLDOFF_MS;
		end
	end

	////////////////////////////////////////////////////////////////
	// object decode and range check
	assign gearOk = objReq.data != 32'h0 && objReq.data <= GEAR_MAX;

	always_comb begin
		sel      = 5'h0;
		hit      = 1'b1;
		readOnly = 1'b0;
		inRange  = 1'b1;
		rdVal    = 32'h0;
		case ({objReq.index, objReq.sub})
			{IDX_PPR, SUB_PPR}: begin
				sel[0]  = 1'b1;
				rdVal   = pprSetting;
				inRange = objReq.data <= PPR_MAX;
			end
			{IDX_ENC_RES, SUB_ENC_RES}: begin
				sel[1]   = 1'b1;
				rdVal    = encRes;
				readOnly = 1'b1;
			end
			{IDX_GEAR, SUB_MOTOR}: begin
				sel[2]  = 1'b1;
				rdVal   = motorRev;
				inRange = gearOk;
			end
			{IDX_GEAR, SUB_SHAFT}: begin
				sel[3]  = 1'b1;
				rdVal   = shaftRev;
				inRange = gearOk;
			end
			{IDX_FEED, SUB_FEED}: begin
				sel[4]  = 1'b1;
				rdVal   = feed;
				inRange = gearOk;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// refused writes leave the stored value untouched
	assign wrOk = objValid && objReq.write && hit && !readOnly && inRange;

	////////////////////////////////////////////////////////////////
	// pulses per revolution: live copy and restart-applied copy
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pprSetting <= PPR_RST;
		end else if (wrOk && sel[0]) begin
			pprSetting <= objReq.data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pprApplied <= PPR_RST;
		end else if (restartReq) begin
			pprApplied <= pprSetting;
		end
	end

	// encoder resolution is filled in once the encoder is known
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			encRes <= ENC_RES_RST;
		end else begin
			encRes <= ENC_COUNTS;
		end
	end

	// gear numerator, denominator and feed constant
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			motorRev <= GEAR_RST;
			shaftRev <= GEAR_RST;
			feed     <= FEED_RST;
		end else if (wrOk) begin
			if (sel[2]) begin
				motorRev <= objReq.data;
			end
			if (sel[3]) begin
				shaftRev <= objReq.data;
			end
			if (sel[4]) begin
				feed <= objReq.data;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// object answer, one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			objAck    <= 1'b0;
			objError  <= 1'b0;
			objRdData <= 32'h0;
		end else begin
			objAck   <= objValid;
			objError <= objValid && (!hit || (objReq.write && (readOnly || !inRange)));
			if (objValid && !objReq.write && hit) begin
				objRdData <= rdVal;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// gear ratio selection
	gear_ratio_select gearSel (
		.clk_sys         (clk_sys),
		.nrst            (nrst),
		.pprApplied      (pprApplied),
		.encRes          (encRes),
		.motorRev        (motorRev),
		.feed            (feed),
		.gearRatio       (gearRatio),
		.gearFromSetting (gearFromSetting),
		.gearClamped     (gearClamped),
		.pprTooLow       (pprTooLow)
	);
endmodule : servo_stop_and_gear_ratio
`default_nettype wire

// [bench/servo_stop_chk.sv]
// assertions on stop sequencer, brake, acknowledge and object port
// assumes binding into servo_stop_and_gear_ratio, single clock domain
`timescale 1ns/10ps
`default_nettype none
module servo_stop_chk
	import servo_stop_pkg::*;
(
	input wire logic               clk_sys,
	input wire logic               nrst,
	input wire logic signed [31:0] motorSpeed,
	input wire logic [31:0]        stopZeroSpeedLevel,
	input wire logic               objValid,
	input wire logic               objAck,
	input wire logic               objError,
	input wire logic               powerOn,
	input wire logic               dynBrakeOn,
	input wire logic               brakeReleaseAsserted,
	input wire logic               servoOnAck,
	input wire logic               cmdPermitted,
	input wire logic               stopActive,
	input wire logic signed [31:0] torqueCmd,
	input wire gear_t              gearRatio,
	input wire logic               gearFromSetting
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	// speed magnitude, unsigned against the threshold
	logic [31:0] absSpeed;
	assign absSpeed = motorSpeed[31] ? 32'(-motorSpeed) : 32'(motorSpeed);
	sequence slowDecel;
		stopActive && absSpeed < stopZeroSpeedLevel;
	endsequence
	sequence stoppedOut;
		!stopActive && !powerOn && !brakeReleaseAsserted && torqueCmd == 0;
	endsequence
	////////////////////////////////////////
	a_obj_answer: assert property (objValid |=> objAck)
		else $error("object request not answered");
	a_obj_quiet: assert property (!objValid |=> !objAck && !objError)
		else $error("object answer without request");
	a_zero_end: assert property (slowDecel |-> ##2 stoppedOut)
		else $error("decel not ended below zero speed");
	a_stop_brake: assert property ($fell(stopActive) |-> stoppedOut)
		else $error("brake not applied at decel end");
	a_decel_held: assert property (stopActive |-> brakeReleaseAsserted && !servoOnAck)
		else $error("brake or ack wrong during decel");
	a_run_outs: assert property (servoOnAck |-> powerOn && brakeReleaseAsserted && !dynBrakeOn)
		else $error("run outputs wrong");
	a_cmd_holdoff: assert property ($rose(servoOnAck) |-> !cmdPermitted [*8])
		else $error("commands permitted too early");
	a_rev_torque: assert property (torqueCmd != 0 |-> stopActive && powerOn && !dynBrakeOn)
		else $error("torque outside reverse decel");
	a_ppr_num: assert property (gearFromSetting |-> gearRatio.num == ENC_COUNTS)
		else $error("setting ratio numerator wrong");
	a_den_nonzero: assert property (gearRatio.den != 32'h0)
		else $error("zero gear denominator");
endmodule : servo_stop_chk
bind servo_stop_and_gear_ratio servo_stop_chk servo_stop_chk_i (.clk_sys, .nrst, .motorSpeed, .stopZeroSpeedLevel,
	.objValid, .objAck, .objError, .powerOn, .dynBrakeOn, .brakeReleaseAsserted, .servoOnAck, .cmdPermitted,
	.stopActive, .torqueCmd, .gearRatio, .gearFromSetting);
`default_nettype wire

// [bench/motor_model.sv]
// behavioural motor with holding brake, answering the power stage
// assumes outputs of the sequencer registered on the rising edge
`timescale 1ns/10ps
`default_nettype none
module motor_model (
	input wire logic               clk_sys,
	input wire logic               slow,
	input wire logic signed [31:0] runSpeed,
	input wire logic               powerOn,
	input wire logic               dynBrakeOn,
	input wire logic               brakeReleaseAsserted,
	input wire logic signed [31:0] torqueCmd,
	output logic signed [31:0]     motorSpeed
);
	initial motorSpeed = 32'sh0;
	// slow freezes speed so only the timeout can end decel
	always @(posedge clk_sys) begin
		if (!brakeReleaseAsserted)
			motorSpeed <= 32'sh0;
		else if (powerOn && torqueCmd == 0)
			motorSpeed <= runSpeed;
		else if (slow)
			motorSpeed <= motorSpeed;
		else if (powerOn)
			motorSpeed <= motorSpeed + (torqueCmd >>> 4);
		else if (dynBrakeOn)
			motorSpeed <= motorSpeed - (motorSpeed >>> 3);
		else
			motorSpeed <= motorSpeed - (motorSpeed >>> 5);
	end
endmodule : motor_model
`default_nettype wire

// [bench/test_servo_stop_and_gear_ratio.sv]
// self-checking bench: object map, gear selection, stop sequences
// assumes motor_model as the far side, inputs driven on falling edges
`timescale 1ns/10ps
`default_nettype none
module test_servo_stop_and_gear_ratio;
	import servo_stop_pkg::*;
	localparam int unsigned MSC = 2;
	logic clk_sys, nrst, servoEnable, alarm, restartReq, objValid, slow, objAck, objError, powerOn, dynBrakeOn;
	logic brakeReleaseAsserted, servoOnAck, cmdPermitted, stopActive, gearFromSetting, gearClamped, pprTooLow;
	logic signed [31:0] motorSpeed, runSpeed, torqueCmd;
	logic [31:0] stopZeroSpeedLevel, objRdData, rnd, ppr, pprNow;
	logic [15:0] stopBrakeTorque, stopDecelTimeout;
	stop_select_t disableStopSelect, alarmStopSelect, sel, oth;
	obj_req_t objReq;
	gear_t gearRatio;
	logic [33:0] note;
	logic [33:0] expQ[$];
	int errTotal, checkCount, cyc, n;
	servo_stop_and_gear_ratio #(.MS_CYCLES(MSC)) servo_stop_and_gear_ratio_i (.clk_sys, .nrst, .servoEnable, .alarm,
		.restartReq, .motorSpeed, .disableStopSelect, .alarmStopSelect, .stopBrakeTorque, .stopDecelTimeout,
		.stopZeroSpeedLevel, .objValid, .objReq, .objAck, .objError, .objRdData, .powerOn, .dynBrakeOn,
		.brakeReleaseAsserted, .servoOnAck, .cmdPermitted, .stopActive, .torqueCmd, .gearRatio, .gearFromSetting,
		.gearClamped, .pprTooLow);
	motor_model motor_model_i (.clk_sys, .slow, .runSpeed, .powerOn, .dynBrakeOn, .brakeReleaseAsserted,
		.torqueCmd, .motorSpeed);
	////////////////////////////////////////
	// clock and hang guard
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			cmpW("timeout", 0, 1);
			end_sim();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic cmpW(input string nm, input logic [31:0] e, input logic [31:0] g);
		checkCount++;
		if (g !== e) begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmpW
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	////////////////////////////////////////
	// object requests: note {error, read-check, data} per request
	task automatic obj(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
		input logic e, input logic [31:0] r);
		@(negedge clk_sys);
		objValid = 1'b1;
		objReq = '{w, i, s, d};
		expQ.push_back({e, !w && !e, r});
	endtask : obj
	task automatic objEnd();
		@(negedge clk_sys);
		objValid = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask : objEnd
	// answers arrive one cycle after each request, oldest note first
	always @(negedge clk_sys) begin
		if (objAck === 1'b1) begin
			note = expQ.size() > 0 ? expQ.pop_front() : 34'h3_FFFF_FFFF;
			cmpW("objError", 32'(note[33]), 32'(objError));
			if (note[32])
				cmpW("objRdData", note[31:0], objRdData);
		end
	end
	task automatic setPpr(input logic [31:0] v);
		obj(1'b1, IDX_PPR, SUB_PPR, v, 1'b0, 32'h0);
		objEnd();
		// the applied copy still holds the previous setting until restart
		cmpW("ratio before restart", 32'(pprNow != 32'h0), 32'(gearFromSetting));
		restartReq = 1'b1;
		@(negedge clk_sys);
		restartReq = 1'b0;
		pprNow = v;
		repeat (4) @(negedge clk_sys);
		cmpW("gearFromSetting", 32'(v != 32'h0), 32'(gearFromSetting));
	endtask : setPpr
	task automatic waitAct(input logic v);
		for (n = 0; n < 400 && stopActive !== v; n++)
			@(negedge clk_sys);
	endtask : waitAct
	task automatic up();
		@(negedge clk_sys);
		servoEnable = 1'b1;
		for (n = 0; n < 8 && servoOnAck !== 1'b1; n++)
			@(negedge clk_sys);
		cmpW("servoOnAck", 1, 32'(servoOnAck));
		cmpW("cmdPermitted early", 0, 32'(cmdPermitted));
		cmpW("brake released", 1, 32'(brakeReleaseAsserted));
		repeat (100 * MSC + 2) @(negedge clk_sys);
		cmpW("cmdPermitted", 1, 32'(cmdPermitted));
	endtask : up
	////////////////////////////////////////
	// main sequence
	initial begin
		{nrst, servoEnable, alarm, restartReq, objValid, slow, cyc, errTotal, checkCount} = '0;
		objReq = '0;
		pprNow = 32'h0;
		runSpeed = 32'sh0000_05DC;
		{disableStopSelect, alarmStopSelect} = 8'h00;
		stopBrakeTorque = 16'h0100;
		stopDecelTimeout = 16'h0FFF;
		stopZeroSpeedLevel = 32'h0000_00C8;
		rnd = 32'h0001_0E11;
		repeat (20) @(negedge clk_sys);
		nrst = 1'b1;
		obj(1'b0, IDX_PPR, SUB_PPR, 32'h0, 1'b0, PPR_RST);
		obj(1'b0, IDX_ENC_RES, SUB_ENC_RES, 32'h0, 1'b0, ENC_COUNTS);
		obj(1'b0, IDX_GEAR, SUB_MOTOR, 32'h0, 1'b0, GEAR_RST);
		obj(1'b0, IDX_GEAR, SUB_SHAFT, 32'h0, 1'b0, GEAR_RST);
		obj(1'b0, IDX_FEED, SUB_FEED, 32'h0, 1'b0, FEED_RST);
		obj(1'b0, 16'h6093, 8'h01, 32'h0, 1'b1, 32'h0);
		obj(1'b1, IDX_ENC_RES, SUB_ENC_RES, 32'h5, 1'b1, 32'h0);
		obj(1'b1, IDX_PPR, SUB_PPR, PPR_MAX + 32'h1, 1'b1, 32'h0);
		obj(1'b1, IDX_GEAR, SUB_MOTOR, 32'h0, 1'b1, 32'h0);
		obj(1'b1, IDX_FEED, SUB_FEED, GEAR_MAX + 32'h1, 1'b1, 32'h0);
		obj(1'b1, IDX_GEAR, SUB_SHAFT, GEAR_MAX, 1'b0, 32'h0);
		obj(1'b0, IDX_GEAR, SUB_SHAFT, 32'h0, 1'b0, GEAR_MAX);
		obj(1'b0, IDX_FEED, SUB_FEED, 32'h0, 1'b0, FEED_RST);
		objEnd();
		cmpW("gear num", ENC_COUNTS, gearRatio.num);
		cmpW("gear den", FEED_RST, gearRatio.den);
		obj(1'b1, IDX_GEAR, SUB_MOTOR, 32'h3, 1'b0, 32'h0);
		obj(1'b1, IDX_FEED, SUB_FEED, ENC_COUNTS, 1'b0, 32'h0);
		objEnd();
		cmpW("gear num", 32'h3, gearRatio.num);
		cmpW("gear den", ENC_COUNTS, gearRatio.den);
		cmpW("gearClamped", 0, 32'(gearClamped));
		// a legal random count at or above the minimum, then one just below it
		rnd = xs(rnd);
		ppr = 32'h0000_0419 + {22'h0, rnd[9:0]};
		setPpr(ppr);
		cmpW("gear den", ppr, gearRatio.den);
		cmpW("pprTooLow", 0, 32'(pprTooLow));
		setPpr(32'h0000_0418);
		cmpW("pprTooLow", 1, 32'(pprTooLow));
		// every method and post-stop state, by disable then by alarm
		for (int i = 0; i < 18; i++) begin
			sel = '{post: 2'(i % 3), method: 2'((i / 3) % 3)};
			oth = '{post: 2'((i + 1) % 3), method: 2'((i / 3 + 1) % 3)};
			disableStopSelect = i < 9 ? sel : oth;
			alarmStopSelect = i < 9 ? oth : sel;
			rnd = xs(rnd);
			runSpeed = (rnd[0] ? -32'sd1 : 32'sd1) * $signed({21'h0, rnd[11:1]} + 32'h0000_03E8);
			up();
			if (i < 9)
				servoEnable = 1'b0;
			else
				alarm = 1'b1;
			waitAct(1'b1);
			cmpW("powerOn decel", 32'(sel.method == 2'h0), 32'(powerOn));
			cmpW("dynBrakeOn decel", 32'(sel.method == 2'h2), 32'(dynBrakeOn));
			cmpW("torqueCmd", sel.method != 2'h0 ? 32'h0 : runSpeed < 0 ? 32'(stopBrakeTorque)
				: -32'(stopBrakeTorque), torqueCmd);
			waitAct(1'b0);
			cmpW("brake after stop", 0, 32'(brakeReleaseAsserted));
			cmpW("dynBrakeOn after stop", 32'(sel.post == 2'h1), 32'(dynBrakeOn));
			{alarm, servoEnable} = 2'b00;
			repeat (3) @(negedge clk_sys);
		end
		// frozen motor: timeout ends decel, alarm takes over mid-stop
		slow = 1'b1;
		runSpeed = 32'sh0000_05DC;
		// unused codes: method falls back to coasting, post-stop to free
		disableStopSelect = '{post: 2'h3, method: 2'h3};
		alarmStopSelect = '{post: 2'h1, method: 2'h0};
		stopDecelTimeout = 16'h0003;
		up();
		servoEnable = 1'b0;
		waitAct(1'b1);
		cmpW("powerOn code 3", 0, 32'(powerOn));
		cmpW("dynBrakeOn code 3", 0, 32'(dynBrakeOn));
		waitAct(1'b0);
		cmpW("decel cycles", 1, 32'(n >= 3 * MSC - 1 && n <= 3 * MSC + 1));
		cmpW("dynBrakeOn post 3", 0, 32'(dynBrakeOn));
		disableStopSelect = '{post: 2'h0, method: 2'h1};
		stopDecelTimeout = 16'h0014;
		up();
		servoEnable = 1'b0;
		waitAct(1'b1);
		cmpW("powerOn coast", 0, 32'(powerOn));
		alarm = 1'b1;
		repeat (3) @(negedge clk_sys);
		cmpW("torqueCmd alarm", -32'(stopBrakeTorque), torqueCmd);
		waitAct(1'b0);
		cmpW("dynBrakeOn alarm post", 1, 32'(dynBrakeOn));
		// enable edge under alarm is ignored, held enable never restarts
		servoEnable = 1'b1;
		repeat (5) @(negedge clk_sys);
		alarm = 1'b0;
		repeat (5) @(negedge clk_sys);
		cmpW("servoOnAck refused", 0, 32'(servoOnAck));
		cmpW("object notes left", 0, expQ.size());
		end_sim();
	end
endmodule : test_servo_stop_and_gear_ratio
`default_nettype wire
